// >>> bench/gtc_pin_model.sv
// far-side model of the timer pins: count pulses, gate levels and trigger level
`timescale 1ns/1ps
module gtc_pin_model (
   // clock and reset
   input wire logic mclk_i,
   input wire logic srst_i,
   // requests from the bench
   input wire logic [2:0] pulse_i,
   input wire logic [1:0] gate_i,
   input wire logic trig_i,
   // pins towards the block
   output gtc_pkg::gtc_pins_s pins_o
);
   import gtc_pkg::*;
   logic [2:0][1:0] hold_q;
   logic [1:0] gate_q;
   logic trig_q;
   // each request gives one high pulse of three cycles, then the pin rests low
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         hold_q <= '0;
         gate_q <= 2'h0;
         trig_q <= 1'b0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            hold_q[i] <= pulse_i[i] ? 2'h3 : ((hold_q[i] != 2'h0) ? hold_q[i] - 2'h1 : 2'h0);
         end
         gate_q <= gate_i;
         trig_q <= trig_i;
      end
   end
   always_comb begin
      pins_o.t0_count_pin = (hold_q[0] != 2'h0);
      pins_o.t1_count_pin = (hold_q[1] != 2'h0);
      pins_o.t2_count_pin = (hold_q[2] != 2'h0);
      pins_o.ext_gate_pin_0 = gate_q[0];
      pins_o.ext_gate_pin_1 = gate_q[1];
      pins_o.trigger_pin = trig_q;
   end
endmodule

// >>> bench/tb_top.sv
// self-checking testbench of the general timers
`timescale 1ns/1ps
module tb_top;
   import gtc_pkg::*;
   logic mclk_i, srst_i, cyc, stb, we, ack_w, t0_ack, t1_ack;
   logic t0_irq_o, t1_irq_o, t2_irq_o, t2_baud_tick_o, trig;
   logic baud_seen = 1'b0;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat_w;
   logic [2:0] pulse;
   logic [1:0] gate;
   gtc_pins_s pins;
   int bad_count, num_checks, ta, tb;
   int cyc_cnt = 0;
   // ****************************************
   // clock, design and pin model
   // ****************************************
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   gtc_timers DUT (.mclk_i(mclk_i), .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack_w), .wb_dat_o(rdat_w),
      .pins_i(pins), .t0_irq_ack_i(t0_ack), .t1_irq_ack_i(t1_ack), .t0_irq_o(t0_irq_o),
      .t1_irq_o(t1_irq_o), .t2_irq_o(t2_irq_o), .t2_baud_tick_o(t2_baud_tick_o));
   gtc_pin_model PINS (.mclk_i(mclk_i), .srst_i(srst_i), .pulse_i(pulse), .gate_i(gate),
      .trig_i(trig), .pins_o(pins));
   always @(posedge mclk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (t2_baud_tick_o === 1'b1) baud_seen <= 1'b1;
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_bit(input string nm, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
      int n;
      @(posedge mclk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      wdat <= {24'h000000, d};
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (ack_w !== 1'b1);
      q = rdat_w;
      cmp_reg("bus latency", 32'd2, 32'(n));
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] q;
      wb(1'b0, a, 8'h00, q);
      cmp_reg($sformatf("reg %h", a), {24'h000000, e}, q);
   endtask
   task automatic pulse_pin(input int k, input int n);
      repeat (n) begin
         @(posedge mclk_i);
         pulse[k] <= 1'b1;
         @(posedge mclk_i);
         pulse[k] <= 1'b0;
         repeat (8) @(posedge mclk_i);
      end
   endtask
   task automatic set_trig(input logic v);
      @(posedge mclk_i);
      trig <= v;
      repeat (6) @(posedge mclk_i);
   endtask
   task automatic wait_t0(output int t);
      int n;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (t0_irq_o !== 1'b1 && n < 400);
      t = cyc_cnt;
      cmp_bit("t0 irq", 1'b1, t0_irq_o);
   endtask
   // ****************************************
   // watchdog
   // ****************************************
   initial begin
      repeat (20000) @(posedge mclk_i);
      bad_count++;
      end_of_test();
   end
   // ****************************************
   // tests
   // ****************************************
   initial begin
      {srst_i, cyc, stb, we, adr, sel, wdat} = {1'b1, 3'h0, 8'h00, 4'h0, 32'h00000000};
      {pulse, gate, trig, t0_ack, t1_ack} = 8'h00;
      {bad_count, num_checks} = {32'd0, 32'd0};
      repeat (8) @(posedge mclk_i);
      srst_i <= 1'b0;
      chk(ADR_T2_CTL, 8'h00);
      chk(ADR_T2_MODE, 8'h00);
      wr(8'h30, 8'h5A);
      chk(8'h30, 8'h00);
      // timer 0 reload mode on the divided clock
      wr(ADR_MODE, 8'h02);
      wr(ADR_T0_LO, 8'hFE);
      wr(ADR_T0_HI, 8'hF0);
      wr(ADR_CTL, 8'h10);
      wait_t0(ta);
      chk(ADR_T0_LO, 8'hF0);
      chk(ADR_T0_HI, 8'hF0);
      @(posedge mclk_i) t0_ack <= 1'b1;
      @(posedge mclk_i) t0_ack <= 1'b0;
      @(posedge mclk_i);
      cmp_bit("t0 irq", 1'b0, t0_irq_o);
      wait_t0(tb);
      cmp_reg("t0 period", 32'd192, 32'(tb - ta));
      // timer 1 as 16-bit event counter, run control and halt
      wr(ADR_CTL, 8'h00);
      wr(ADR_MODE, 8'h50);
      wr(ADR_T1_LO, 8'hFE);
      wr(ADR_T1_HI, 8'h00);
      wr(ADR_CTL, 8'h40);
      pulse_pin(1, 3);
      chk(ADR_T1_LO, 8'h01);
      chk(ADR_T1_HI, 8'h01);
      wr(ADR_CTL, 8'h00);
      pulse_pin(1, 2);
      chk(ADR_T1_LO, 8'h01);
      wr(ADR_MODE, 8'h70);
      wr(ADR_CTL, 8'h40);
      pulse_pin(1, 2);
      chk(ADR_T1_LO, 8'h01);
      // timer 0 13-bit mode, then gated counting
      wr(ADR_CTL, 8'h00);
      wr(ADR_MODE, 8'h04);
      wr(ADR_T0_LO, 8'hFF);
      wr(ADR_T0_HI, 8'h00);
      wr(ADR_CTL, 8'h10);
      pulse_pin(0, 1);
      chk(ADR_T0_LO, 8'hE0);
      chk(ADR_T0_HI, 8'h01);
      wr(ADR_CTL, 8'h00);
      wr(ADR_MODE, 8'h0D);
      wr(ADR_T0_LO, 8'h00);
      wr(ADR_CTL, 8'h10);
      pulse_pin(0, 2);
      chk(ADR_T0_LO, 8'h00);
      @(posedge mclk_i) gate <= 2'h1;
      pulse_pin(0, 3);
      chk(ADR_T0_LO, 8'h03);
      // timer 0 mode 3: high byte borrows timer 1 run bit and flag
      wr(ADR_CTL, 8'h00);
      wr(ADR_MODE, 8'h03);
      wr(ADR_T0_HI, 8'hFF);
      wr(ADR_CTL, 8'h40);
      repeat (20) @(posedge mclk_i);
      cmp_bit("t1 irq", 1'b1, t1_irq_o);
      chk(ADR_T0_LO, 8'h03);
      @(posedge mclk_i) t1_ack <= 1'b1;
      @(posedge mclk_i) t1_ack <= 1'b0;
      @(posedge mclk_i);
      cmp_bit("t1 irq", 1'b0, t1_irq_o);
      wr(ADR_CTL, 8'h00);
      wr(ADR_MODE, 8'h00);
      // timer 2 capture mode
      wr(ADR_T2_CTL, 8'h0F);
      pulse_pin(2, 3);
      set_trig(1'b1);
      set_trig(1'b0);
      chk(ADR_CAP_LO, 8'h03);
      chk(ADR_CAP_HI, 8'h00);
      chk(ADR_T2_LO, 8'h03);
      chk(ADR_T2_CTL, 8'h4F);
      cmp_bit("t2 irq", 1'b1, t2_irq_o);
      wr(ADR_T2_CTL, 8'h0F);
      wr(ADR_T2_LO, 8'hFF);
      wr(ADR_T2_HI, 8'hFF);
      pulse_pin(2, 1);
      chk(ADR_T2_CTL, 8'h8F);
      chk(ADR_T2_LO, 8'h00);
      // timer 2 auto-reload, up counting
      wr(ADR_T2_CTL, 8'h00);
      wr(ADR_CAP_LO, 8'h34);
      wr(ADR_CAP_HI, 8'h12);
      wr(ADR_T2_LO, 8'hFE);
      wr(ADR_T2_HI, 8'hFF);
      wr(ADR_T2_CTL, 8'h06);
      pulse_pin(2, 2);
      chk(ADR_T2_LO, 8'h34);
      chk(ADR_T2_HI, 8'h12);
      chk(ADR_T2_CTL, 8'h86);
      wr(ADR_T2_CTL, 8'h0E);
      pulse_pin(2, 1);
      set_trig(1'b1);
      set_trig(1'b0);
      chk(ADR_T2_LO, 8'h34);
      chk(ADR_T2_CTL, 8'h4E);
      // timer 2 up/down counting
      wr(ADR_T2_CTL, 8'h00);
      wr(ADR_T2_MODE, 8'h01);
      wr(ADR_T2_LO, 8'h34);
      wr(ADR_T2_HI, 8'h12);
      wr(ADR_T2_CTL, 8'h06);
      pulse_pin(2, 1);
      chk(ADR_T2_LO, 8'hFF);
      chk(ADR_T2_HI, 8'hFF);
      chk(ADR_T2_CTL, 8'hC6);
      wr(ADR_T2_CTL, 8'h46);
      repeat (2) @(posedge mclk_i);
      cmp_bit("t2 irq", 1'b0, t2_irq_o);
      set_trig(1'b1);
      pulse_pin(2, 1);
      chk(ADR_T2_LO, 8'h34);
      chk(ADR_T2_CTL, 8'h86);
      cmp_bit("t2 irq", 1'b1, t2_irq_o);
      // timer 2 baud mode
      wr(ADR_T2_MODE, 8'h00);
      wr(ADR_T2_CTL, 8'h00);
      wr(ADR_T2_LO, 8'hFF);
      wr(ADR_T2_HI, 8'hFF);
      wr(ADR_T2_CTL, 8'h16);
      pulse_pin(2, 1);
      cmp_bit("baud tick", 1'b1, baud_seen);
      chk(ADR_T2_CTL, 8'h16);
      chk(ADR_T2_LO, 8'h34);
      end_of_test();
   end
endmodule

// >>> rtl/gtc_pkg.sv
// package: register map, field layouts and state record of the general timers
package gtc_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned PRESCALE_DIV = 12;
   localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_DIV - 1);

   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [7:0] ADR_MODE = 8'h00;
   localparam logic [7:0] ADR_CTL = 8'h04;
   localparam logic [7:0] ADR_T0_LO = 8'h08;
   localparam logic [7:0] ADR_T0_HI = 8'h0C;
   localparam logic [7:0] ADR_T1_LO = 8'h10;
   localparam logic [7:0] ADR_T1_HI = 8'h14;
   localparam logic [7:0] ADR_T2_CTL = 8'h18;
   localparam logic [7:0] ADR_T2_MODE = 8'h1C;
   localparam logic [7:0] ADR_T2_LO = 8'h20;
   localparam logic [7:0] ADR_T2_HI = 8'h24;
   localparam logic [7:0] ADR_CAP_LO = 8'h28;
   localparam logic [7:0] ADR_CAP_HI = 8'h2C;

   // ****************************************
   // timer 0/1 modes and count limits
   // ****************************************
   localparam logic [1:0] MODE_13BIT = 2'h0;
   localparam logic [1:0] MODE_16BIT = 2'h1;
   localparam logic [1:0] MODE_8BIT_RELOAD = 2'h2;
   localparam logic [1:0] MODE_HALT = 2'h3;
   localparam logic [4:0] PRESCALE5_TOP = 5'h1F;
   localparam logic [7:0] BYTE_TOP = 8'hFF;
   localparam logic [15:0] WORD_TOP = 16'hFFFF;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;

   // ****************************************
   // field layouts
   // ****************************************
   typedef struct packed {
      logic t1_gate_bit;
      logic t1_counter_select;
      logic [1:0] t1_mode;
      logic t0_gate_bit;
      logic t0_counter_select;
      logic [1:0] t0_mode;
   } gtc_mode_s;

   typedef struct packed {
      logic t1_overflow_flag;
      logic t1_run_bit;
      logic t0_overflow_flag;
      logic t0_run_bit;
      logic [3:0] rsvd;
   } gtc_ctl_s;

   typedef struct packed {
      logic t2_overflow_flag;
      logic t2_external_flag;
      logic receive_baud_select;
      logic transmit_baud_select;
      logic t2_external_enable;
      logic t2_run_bit;
      logic t2_counter_select;
      logic capture_reload_select;
   } gtc_t2ctl_s;

   typedef struct packed {
      logic t0_count_pin;
      logic t1_count_pin;
      logic t2_count_pin;
      logic ext_gate_pin_0;
      logic ext_gate_pin_1;
      logic trigger_pin;
   } gtc_pins_s;

   typedef struct packed {
      logic [3:0] pre;
      logic tick;
      logic [3:0] pin_prev;
      gtc_mode_s mode;
      gtc_ctl_s ctl;
      logic [7:0] t0_lo;
      logic [7:0] t0_hi;
      logic [7:0] t1_lo;
      logic [7:0] t1_hi;
      gtc_t2ctl_s t2ctl;
      logic down_count_enable;
      logic [15:0] t2_cnt;
      logic [15:0] cap;
      logic t2_irq;
      logic baud_tick;
      logic ack;
      logic [31:0] dat;
   } gtc_state_s;

endpackage

// >>> rtl/gtc_timers.sv
// general timers 0, 1 and 2 with capture, reload and up/down counting, wishbone register slave
//
// How it works
// - 13-bit mode: 5-bit low prescaler feeds 8-bit high byte; upper low bits untouched.
// - 16-bit mode: low and high bytes cascade, count input bumps the low byte.
// - 8-bit reload: low byte overflow sets flag, reloads from high byte unchanged.
// - timer 1 in mode 3 halts and holds its count.
// - reload period is 256 minus start or reload value; flag cleared on service.
// - gate and run set: count only while the external gate pin is high.
// - run bit clear stops counting, set starts it; timer 1 counts regardless of its run bit while timer 0 is in mode 3.
// - timer 2 is a 16-bit counter fed by divided clock or its count pin.
// - after reset timer 2 is in auto-reload mode.
// - capture mode: timer 2 overflow sets its overflow flag.
// - capture mode with enable: trigger falling edge copies count, sets external flag.
// - with down-count enable clear, overflow or external flag raises timer 2 request.
// - reset clears down-count enable, so timer 2 counts up.
// - up count reaches FFFF, sets flag, loads capture/reload value.
// - with enable set, trigger falling edge also reloads and sets external flag.
// - up/down with trigger high: count up, reload from capture/reload at FFFF.
// - up/down with trigger low: count down, at capture/reload value load FFFF.
// - up/down: external flag toggles on wrap, no request, acts as 17th bit.
// - either baud select bit puts timer 2 in baud generator mode.
// - select bit set: count falling edges on the count pin.
// - timer 0 mode 3: its high byte uses timer 1 run bit and flag.
// - timer 2 flag stays until software clears; never set in baud mode.
//
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/1ps
module gtc_timers (
   // clock and reset
   input wire logic mclk_i,
   input wire logic srst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   // external pins
   input wire gtc_pkg::gtc_pins_s pins_i,
   // interrupt service acknowledges
   input wire logic t0_irq_ack_i,
   input wire logic t1_irq_ack_i,
   // requests and status
   output logic t0_irq_o,
   output logic t1_irq_o,
   output logic t2_irq_o,
   output logic t2_baud_tick_o
);
   import gtc_pkg::*;

   gtc_state_s q;
   gtc_state_s d;

   logic acc, wr;
   logic [7:0] wdat;
   logic fall0, fall1, fall2, trig_fall;
   logic t0_m3, run1;
   logic inc0, inc1, inc0_hi, inc2;
   logic set_tf0, set_tf1, set_tf2, set_exf, tog_exf;
   logic baud, capmode, updown, ext_evt, t2_wrap;
   logic [16:0] s0, s1;
   logic [15:0] cnt_n, cap_n;
   gtc_ctl_s ctl_b;
   gtc_t2ctl_s t2_b;

   // ****************************************
   // timer 0/1 step: returns {overflow, high, low}
   // ****************************************
   function automatic logic [16:0] step8(input logic [1:0] md, input logic [7:0] lo, input logic [7:0] hi,
                                         input logic inc);
      logic [16:0] r;
      r = {1'b0, hi, lo};
      if (inc) begin
         unique case (md)
            MODE_13BIT: begin
               r[4:0] = lo[4:0] + 5'h01;
               if (lo[4:0] == PRESCALE5_TOP) begin
                  r[15:8] = hi + 8'h01;
                  r[16] = (hi == BYTE_TOP);
               end
            end
            MODE_16BIT: begin
               r = {1'b0, hi, lo} + 17'h00001;
            end
            MODE_8BIT_RELOAD: begin
               if (lo == BYTE_TOP) begin
                  r = {1'b1, hi, hi};
               end else begin
                  r[7:0] = lo + 8'h01;
               end
            end
            MODE_HALT: begin
               r = {1'b0, hi, lo};
            end
         endcase
      end
      return r;
   endfunction

   // ****************************************
   // register read mux
   // ****************************************
   function automatic logic [7:0] rd_mux(input gtc_state_s s, input logic [7:0] a);
      logic [7:0] v;
      v = RST_BYTE;
      unique case (a)
         ADR_MODE: v = s.mode;
         ADR_CTL: v = {s.ctl.t1_overflow_flag, s.ctl.t1_run_bit, s.ctl.t0_overflow_flag, s.ctl.t0_run_bit, 4'h0};
         ADR_T0_LO: v = s.t0_lo;
         ADR_T0_HI: v = s.t0_hi;
         ADR_T1_LO: v = s.t1_lo;
         ADR_T1_HI: v = s.t1_hi;
         ADR_T2_CTL: v = s.t2ctl;
         ADR_T2_MODE: v = {7'h00, s.down_count_enable};
         ADR_T2_LO: v = s.t2_cnt[7:0];
         ADR_T2_HI: v = s.t2_cnt[15:8];
         ADR_CAP_LO: v = s.cap[7:0];
         ADR_CAP_HI: v = s.cap[15:8];
         default: v = RST_BYTE;
      endcase
      return v;
   endfunction

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      d = q;
      // bus handshake: ack one cycle after request, write at the acked edge
      acc = wb_cyc_i & wb_stb_i;
      wr = acc & wb_we_i & q.ack & wb_sel_i[0];
      wdat = wb_dat_i[7:0];
      d.ack = acc & ~q.ack;
      d.dat = (acc & ~q.ack) ? {24'h000000, rd_mux(q, wb_adr_i)} : 32'h00000000;

      // divide-by-twelve peripheral tick
      d.tick = (q.pre == PRESCALE_LAST);
      d.pre = d.tick ? 4'h0 : q.pre + 4'h1;

      // pin sampling and falling edges
      d.pin_prev = {pins_i.t0_count_pin, pins_i.t1_count_pin, pins_i.t2_count_pin, pins_i.trigger_pin};
      fall0 = q.pin_prev[3] & ~pins_i.t0_count_pin;
      fall1 = q.pin_prev[2] & ~pins_i.t1_count_pin;
      fall2 = q.pin_prev[1] & ~pins_i.t2_count_pin;
      trig_fall = q.pin_prev[0] & ~pins_i.trigger_pin;

      // timer 0/1 count enables
      t0_m3 = (q.mode.t0_mode == MODE_HALT);
      run1 = t0_m3 | q.ctl.t1_run_bit;
      inc0 = q.ctl.t0_run_bit & (~q.mode.t0_gate_bit | pins_i.ext_gate_pin_0)
             & (q.mode.t0_counter_select ? fall0 : q.tick);
      inc1 = run1 & (~q.mode.t1_gate_bit | pins_i.ext_gate_pin_1)
             & (q.mode.t1_counter_select ? fall1 : q.tick);
      inc0_hi = q.ctl.t1_run_bit & q.tick;

      if (t0_m3) begin
         s0[7:0] = inc0 ? q.t0_lo + 8'h01 : q.t0_lo;
         s0[15:8] = inc0_hi ? q.t0_hi + 8'h01 : q.t0_hi;
         s0[16] = inc0 & (q.t0_lo == BYTE_TOP);
      end else begin
         s0 = step8(q.mode.t0_mode, q.t0_lo, q.t0_hi, inc0);
      end
      s1 = step8(q.mode.t1_mode, q.t1_lo, q.t1_hi, inc1);
      set_tf0 = s0[16];
      set_tf1 = t0_m3 ? (inc0_hi & (q.t0_hi == BYTE_TOP)) : s1[16];
      d.t0_lo = s0[7:0];
      d.t0_hi = s0[15:8];
      d.t1_lo = s1[7:0];
      d.t1_hi = s1[15:8];

      // ****************************************
      // timer 2
      // ****************************************
      baud = q.t2ctl.receive_baud_select | q.t2ctl.transmit_baud_select;
      capmode = q.t2ctl.capture_reload_select & ~baud;
      updown = q.down_count_enable & ~q.t2ctl.capture_reload_select & ~baud;
      ext_evt = q.t2ctl.t2_external_enable & trig_fall & ~baud;
      inc2 = q.t2ctl.t2_run_bit & (q.t2ctl.t2_counter_select ? fall2 : q.tick);
      set_tf2 = 1'b0;
      set_exf = 1'b0;
      tog_exf = 1'b0;
      t2_wrap = 1'b0;
      cnt_n = q.t2_cnt;
      cap_n = q.cap;
      if (capmode) begin
         if (inc2) begin
            cnt_n = q.t2_cnt + 16'h0001;
            set_tf2 = (q.t2_cnt == WORD_TOP);
         end
         if (ext_evt) begin
            cap_n = q.t2_cnt;
            set_exf = 1'b1;
         end
      end else if (updown) begin
         if (inc2) begin
            if (pins_i.trigger_pin) begin
               if (q.t2_cnt == WORD_TOP) begin
                  cnt_n = q.cap;
                  set_tf2 = 1'b1;
                  tog_exf = 1'b1;
               end else begin
                  cnt_n = q.t2_cnt + 16'h0001;
               end
            end else begin
               if (q.t2_cnt == q.cap) begin
                  cnt_n = WORD_TOP;
                  set_tf2 = 1'b1;
                  tog_exf = 1'b1;
               end else begin
                  cnt_n = q.t2_cnt - 16'h0001;
               end
            end
         end
      end else begin
         if (inc2) begin
            if (q.t2_cnt == WORD_TOP) begin
               cnt_n = q.cap;
               t2_wrap = 1'b1;
               set_tf2 = ~baud;
            end else begin
               cnt_n = q.t2_cnt + 16'h0001;
            end
         end
         if (ext_evt) begin
            cnt_n = q.cap;
            set_exf = 1'b1;
         end
      end
      d.baud_tick = baud & t2_wrap;

      // ****************************************
      // software writes; counting is overridden, flag sets win
      // ****************************************
      ctl_b = q.ctl;
      ctl_b.t0_overflow_flag = q.ctl.t0_overflow_flag & ~t0_irq_ack_i;
      ctl_b.t1_overflow_flag = q.ctl.t1_overflow_flag & ~t1_irq_ack_i;
      t2_b = q.t2ctl;
      if (wr) begin
         unique case (wb_adr_i)
            ADR_MODE: d.mode = wdat;
            ADR_CTL: ctl_b = {wdat[7:4], 4'h0};
            ADR_T0_LO: d.t0_lo = wdat;
            ADR_T0_HI: d.t0_hi = wdat;
            ADR_T1_LO: d.t1_lo = wdat;
            ADR_T1_HI: d.t1_hi = wdat;
            ADR_T2_CTL: t2_b = wdat;
            ADR_T2_MODE: d.down_count_enable = wdat[0];
            ADR_T2_LO: cnt_n[7:0] = wdat;
            ADR_T2_HI: cnt_n[15:8] = wdat;
            ADR_CAP_LO: cap_n[7:0] = wdat;
            ADR_CAP_HI: cap_n[15:8] = wdat;
            default: ;
         endcase
      end
      d.ctl = ctl_b;
      d.ctl.t0_overflow_flag = ctl_b.t0_overflow_flag | set_tf0;
      d.ctl.t1_overflow_flag = ctl_b.t1_overflow_flag | set_tf1;
      d.t2ctl = t2_b;
      d.t2ctl.t2_overflow_flag = t2_b.t2_overflow_flag | set_tf2;
      d.t2ctl.t2_external_flag = tog_exf ? ~q.t2ctl.t2_external_flag : (t2_b.t2_external_flag | set_exf);
      d.t2_cnt = cnt_n;
      d.cap = cap_n;
      d.t2_irq = d.t2ctl.t2_overflow_flag | (d.t2ctl.t2_external_flag & ~d.down_count_enable);
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.dat;
   assign t0_irq_o = q.ctl.t0_overflow_flag;
   assign t1_irq_o = q.ctl.t1_overflow_flag;
   assign t2_irq_o = q.t2_irq;
   assign t2_baud_tick_o = q.baud_tick;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (srst_i);

   sequence s_tick_gap;
      !q.tick [*8] ##1 !q.tick [*3] ##1 q.tick;
   endsequence

   sequence s_capture_seen;
      q.cap == $past(q.t2_cnt) && q.t2ctl.t2_external_flag;
   endsequence

   AST_PRESCALE_TWELVE: assert property (q.tick |=> s_tick_gap)
      else $error("peripheral tick not every twelve clocks");

   AST_T1_HALT_HOLDS: assert property ((q.mode.t1_mode == MODE_HALT) && !wr |=>
      {q.t1_hi, q.t1_lo} == $past({q.t1_hi, q.t1_lo}))
      else $error("timer 1 moved while halted");

   AST_T0_STOPPED: assert property (!q.ctl.t0_run_bit && !t0_m3 && !wr |=>
      {q.t0_hi, q.t0_lo} == $past({q.t0_hi, q.t0_lo}))
      else $error("timer 0 counted with run bit clear");

   AST_T0_GATED: assert property (q.mode.t0_gate_bit && !pins_i.ext_gate_pin_0 && !t0_m3 && !wr |=>
      {q.t0_hi, q.t0_lo} == $past({q.t0_hi, q.t0_lo}))
      else $error("timer 0 counted with gate pin low");

   AST_T0_RELOAD: assert property ((q.mode.t0_mode == MODE_8BIT_RELOAD) && inc0 && (q.t0_lo == BYTE_TOP) && !wr
      |=> q.t0_lo == $past(q.t0_hi) && q.t0_hi == $past(q.t0_hi) && q.ctl.t0_overflow_flag)
      else $error("timer 0 reload wrong");

   AST_T1_13BIT_UPPER: assert property ((q.mode.t1_mode == MODE_13BIT) && !wr |=>
      q.t1_lo[7:5] == $past(q.t1_lo[7:5]))
      else $error("13-bit mode touched upper low bits");

   AST_T2_CAPTURE: assert property (capmode && ext_evt && !wr |=> s_capture_seen)
      else $error("capture did not copy count or set external flag");

   AST_T2_UP_RELOAD: assert property (!capmode && !updown && !baud && inc2 && (q.t2_cnt == WORD_TOP) && !wr
      |=> q.t2_cnt == $past(q.cap) && q.t2ctl.t2_overflow_flag)
      else $error("timer 2 up reload wrong");

   AST_T2_DOWN_WRAP: assert property (updown && inc2 && !pins_i.trigger_pin && (q.t2_cnt == q.cap) && !wr
      |=> q.t2_cnt == WORD_TOP && q.t2ctl.t2_external_flag != $past(q.t2ctl.t2_external_flag))
      else $error("timer 2 underflow wrong");

   AST_T2_BAUD_NO_FLAG: assert property (baud && !q.t2ctl.t2_overflow_flag && !wr |=>
      !q.t2ctl.t2_overflow_flag)
      else $error("overflow flag set in baud mode");

   AST_T2_UPDOWN_NO_IRQ: assert property (q.down_count_enable && !q.t2ctl.t2_overflow_flag |-> !q.t2_irq)
      else $error("external flag raised a request in up/down mode");

   AST_T2_EXT_IRQ: assert property (!q.down_count_enable && q.t2ctl.t2_external_flag |-> q.t2_irq)
      else $error("external flag did not raise timer 2 request");

   AST_T0_HI_NEEDS_T1_RUN: assert property (t0_m3 && !q.ctl.t1_run_bit && !wr |=>
      q.t0_hi == $past(q.t0_hi))
      else $error("timer 0 high byte counted without timer 1 run bit");

   AST_T0_HI_SETS_T1_FLAG: assert property (t0_m3 && q.ctl.t1_run_bit && q.tick && (q.t0_hi == BYTE_TOP)
      && !wr |=> q.t0_hi == RST_BYTE && q.ctl.t1_overflow_flag)
      else $error("timer 0 high byte overflow did not set timer 1 flag");

   AST_T0_FLAG_SERVICED: assert property (q.ctl.t0_overflow_flag && t0_irq_ack_i && !set_tf0 && !wr |=>
      !q.ctl.t0_overflow_flag)
      else $error("timer 0 flag not cleared by service acknowledge");

   AST_T2_CAPTURE_COUNTS: assert property (capmode && inc2 && !wr |=>
      q.t2_cnt == $past(q.t2_cnt) + 16'h0001)
      else $error("timer 2 did not step in capture mode");

   AST_T2_EDGE_RELOAD: assert property (!capmode && !updown && ext_evt && !wr |=>
      q.t2_cnt == $past(q.cap) && q.t2ctl.t2_external_flag)
      else $error("trigger edge did not reload timer 2");

   AST_T2_UP_WRAP: assert property (updown && inc2 && pins_i.trigger_pin && (q.t2_cnt == WORD_TOP) && !wr
      |=> q.t2_cnt == $past(q.cap) && q.t2ctl.t2_overflow_flag && q.t2_irq)
      else $error("timer 2 up/down overflow wrong");

   AST_BUS_ACK_PULSE: assert property (q.ack |=> !q.ack)
      else $error("ack held two cycles");

endmodule
